// ### rtl/float_arith_pkg.sv
package float_arith_pkg;

  // ****************************************
  // opcode decode
  // ****************************************
  typedef enum logic [1:0] {
    float_add_op,
    float_subtract_op,
    float_multiply_op,
    float_divide_op
  } float_op_t;

  // opcode bits 15:5 shared by all four floating instructions
  localparam logic [10:0] FLOAT_OPCODE_PREFIX = 11'h03d0;

  // ****************************************
  // operand placement, byte offsets from pointer
  // ****************************************
  localparam logic [15:0] SRC_HI_OFFSET = 16'h0000;
  localparam logic [15:0] SRC_LO_OFFSET = 16'h0002;
  localparam logic [15:0] ACC_HI_OFFSET = 16'h0004;
  localparam logic [15:0] ACC_LO_OFFSET = 16'h0006;

  // ****************************************
  // number format and exponent limits
  // ****************************************
  localparam logic signed [9:0] EXP_BIAS             = 10'h080;
  localparam logic signed [9:0] exponent_upper_limit = 10'h0ff;
  localparam logic signed [9:0] exponent_lower_limit = 10'h001;
  localparam logic [23:0]       HIDDEN_ONE           = 24'h80_0000;

  typedef struct packed {
    logic        sign;
    logic [7:0]  exp;
    logic [22:0] frac;
  } float_word_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cond_codes_t;

endpackage

// ### rtl/float_arith_unit.sv
`timescale 1ns/1ps
module float_arith_unit
  import float_arith_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CMD_VALID_IN,
  input  wire logic [15:0] CMD_OPCODE_IN,
  input  wire logic [15:0] OPERAND_POINTER_IN,
  output logic             CMD_READY_OUT,
  output logic             MEM_REQ_OUT,
  output logic             MEM_WE_OUT,
  output logic [15:0]      MEM_ADDR_OUT,
  output logic [15:0]      MEM_WDATA_OUT,
  input  wire logic        MEM_ACK_IN,
  input  wire logic [15:0] MEM_RDATA_IN,
  output logic             DONE_OUT,
  output cond_codes_t      FLAGS_OUT
);

  typedef enum logic [2:0] {IDLE, READ, CALC, WRITE, FINISH} state_t;

  state_t            state;
  float_op_t         op;
  logic [15:0]       float_operand_pointer;
  logic [1:0]        word_idx;
  logic [3:0][15:0]  op_words;
  float_word_t       float_accumulator;
  float_word_t       float_source;
  float_word_t       float_temp_result;
  logic              unf_q;
  logic              accept;
  logic              is_float_op;

  // ****************************************
  // command decode
  // ****************************************
  assign is_float_op   = CMD_OPCODE_IN[15:5] == FLOAT_OPCODE_PREFIX;
  assign CMD_READY_OUT = state == IDLE;
  assign accept        = CMD_VALID_IN && CMD_READY_OUT && is_float_op;
  assign MEM_REQ_OUT   = (state == READ) || (state == WRITE);
  assign MEM_WE_OUT    = state == WRITE;
  assign DONE_OUT      = state == FINISH;

  // words in fetch order: src hi, src lo, acc hi, acc lo
  function automatic logic [15:0] word_offset(input logic [1:0] idx);
    unique case (idx)
      2'h0: word_offset = SRC_HI_OFFSET;
      2'h1: word_offset = SRC_LO_OFFSET;
      2'h2: word_offset = ACC_HI_OFFSET;
      2'h3: word_offset = ACC_LO_OFFSET;
    endcase
  endfunction

  assign float_source      = {op_words[0], op_words[1]};
  assign float_accumulator = {op_words[2], op_words[3]};

  // ****************************************
  // arithmetic datapath
  // ****************************************
  logic              a_zero, b_zero, b_sign, swap, div_zero, ovf, unf, store;
  logic [23:0]       ma, mb, m_big, m_small;
  logic [47:0]       prod, quot;
  logic [24:0]       raw_m, nm;
  logic signed [9:0] raw_e, ne;
  logic [7:0]        exp_diff;
  logic              res_sign;
  float_word_t       next_result;

  // one combinational pass; divide uses the plain operator, traded area for latency
  always_comb
  begin
    a_zero   = float_accumulator.exp == 8'h00;
    b_zero   = float_source.exp == 8'h00;
    b_sign   = float_source.sign ^ (op == float_subtract_op);
    ma       = HIDDEN_ONE | {1'b0, float_accumulator.frac};
    mb       = HIDDEN_ONE | {1'b0, float_source.frac};
    swap     = {float_source.exp, float_source.frac} >
               {float_accumulator.exp, float_accumulator.frac};
    m_big    = swap ? mb : ma;
    m_small  = swap ? ma : mb;
    exp_diff = swap ? float_source.exp - float_accumulator.exp
                    : float_accumulator.exp - float_source.exp;
    m_small  = (exp_diff > 8'h17) ? 24'h00_0000 : (m_small >> exp_diff);
    prod     = ma * mb;
    quot     = b_zero ? 48'h0000_0000_0000 : ({ma, 24'h00_0000} / {24'h00_0000, mb});
    div_zero = 1'b0;
    res_sign = 1'b0;
    raw_m    = 25'h000_0000;
    raw_e    = 10'h000;
    unique case (op)
      // add, subtract with source sign turned
      float_add_op, float_subtract_op:
      begin
        res_sign = swap ? b_sign : float_accumulator.sign;
        raw_e    = {2'b00, swap ? float_source.exp : float_accumulator.exp};
        if (float_accumulator.sign == b_sign)
          raw_m = {1'b0, m_big} + {1'b0, m_small};
        else
          raw_m = {1'b0, m_big} - {1'b0, m_small};
        if (a_zero)
        begin
          res_sign = b_sign;
          raw_m    = b_zero ? 25'h000_0000 : {1'b0, mb};
          raw_e    = {2'b00, float_source.exp};
        end
        else if (b_zero)
        begin
          res_sign = float_accumulator.sign;
          raw_m    = {1'b0, ma};
          raw_e    = {2'b00, float_accumulator.exp};
        end
      end
      float_multiply_op:
      begin
        res_sign = float_accumulator.sign ^ float_source.sign;
        raw_m    = (a_zero || b_zero) ? 25'h000_0000 : prod[47:23];
        raw_e    = {2'b00, float_accumulator.exp} + {2'b00, float_source.exp} - EXP_BIAS;
      end
      float_divide_op:
      begin
        div_zero = b_zero;
        res_sign = float_accumulator.sign ^ float_source.sign;
        raw_m    = (a_zero || b_zero) ? 25'h000_0000 : quot[24:0];
        raw_e    = {2'b00, float_accumulator.exp} - {2'b00, float_source.exp}
                   + EXP_BIAS - 10'sh001;
      end
    endcase
    // normalise: carry out first, then shift up to hidden bit
    nm = raw_m;
    ne = raw_e;
    if (nm[24])
    begin
      nm = nm >> 1;
      ne = ne + 10'sh001;
    end
    for (int i = 0; i < 23; i++)
    begin
      if (!nm[23] && (nm != 25'h000_0000))
      begin
        nm = nm << 1;
        ne = ne - 10'sh001;
      end
    end
    ovf   = (nm != 25'h000_0000) && (ne > exponent_upper_limit);
    unf   = (nm != 25'h000_0000) && (ne < exponent_lower_limit);
    store = !div_zero && !ovf && !unf;
    if (nm == 25'h000_0000)
      next_result = '0;
    else
      next_result = {res_sign, ne[7:0], nm[22:0]};
  end

  // ****************************************
  // sequencer
  // ****************************************
  // fetch four words, compute, write two words only when in range
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      state    <= IDLE;
      word_idx <= 2'h0;
    end
    else
    begin
      unique case (state)
        IDLE:
          if (accept)
          begin
            state    <= READ;
            word_idx <= 2'h0;
          end
        READ:
          if (MEM_ACK_IN)
          begin
            word_idx <= word_idx + 2'h1;
            if (word_idx == 2'h3)
              state <= CALC;
          end
        CALC:
        begin
          word_idx <= 2'h0;
          state    <= store ? WRITE : FINISH;
        end
        WRITE:
          if (MEM_ACK_IN)
          begin
            word_idx <= word_idx + 2'h1;
            if (word_idx == 2'h1)
              state <= FINISH;
          end
        FINISH:
          state <= IDLE;
      endcase
    end
  end

  // latched command fields
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      op                    <= float_add_op;
      float_operand_pointer <= 16'h0000;
    end
    else if (accept)
    begin
      op                    <= float_op_t'(CMD_OPCODE_IN[4:3]);
      float_operand_pointer <= OPERAND_POINTER_IN;
    end
  end

  // operand word capture, one slot per fetch index
  for (genvar g = 0; g < 4; g++)
  begin : g_capture
    always_ff @(posedge SYS_CLK_IN)
    begin
      if (RST_IN)
        op_words[g] <= 16'h0000;
      else if ((state == READ) && MEM_ACK_IN && (word_idx == 2'(g)))
        op_words[g] <= MEM_RDATA_IN;
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      MEM_ADDR_OUT  <= 16'h0000;
      MEM_WDATA_OUT <= 16'h0000;
    end
    else if (accept)
      MEM_ADDR_OUT <= OPERAND_POINTER_IN + SRC_HI_OFFSET;
    else if ((state == READ) && MEM_ACK_IN)
      MEM_ADDR_OUT <= float_operand_pointer + word_offset(word_idx + 2'h1);
    else if (state == CALC)
    begin
      MEM_ADDR_OUT  <= float_operand_pointer + ACC_HI_OFFSET;
      MEM_WDATA_OUT <= next_result[31:16];
    end
    else if ((state == WRITE) && MEM_ACK_IN && (word_idx == 2'h0))
    begin
      MEM_ADDR_OUT  <= float_operand_pointer + ACC_LO_OFFSET;
      MEM_WDATA_OUT <= float_temp_result[15:0];
    end
  end

  // temp result and condition codes settle in the compute cycle
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      float_temp_result <= '0;
      unf_q             <= 1'b0;
      FLAGS_OUT         <= '0;
    end
    else if (state == CALC)
    begin
      float_temp_result <= next_result;
      unf_q             <= unf;
      FLAGS_OUT.n <= (store ? next_result.sign : float_accumulator.sign) | unf;
      // zero test on the final accumulator
      FLAGS_OUT.z <= (store ? next_result : float_accumulator) == 32'h0000_0000;
      FLAGS_OUT.v <= ovf | unf;
      // carry only for divide by zero
      FLAGS_OUT.c <= div_zero;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  a_src_first_addr: assert property (
    accept |=> MEM_ADDR_OUT == $past(OPERAND_POINTER_IN) + SRC_HI_OFFSET)
    else $error("first fetch not at source high word");
  a_acc_write_addr: assert property (
    (MEM_WE_OUT && word_idx == 2'h0) |-> MEM_ADDR_OUT == float_operand_pointer + ACC_HI_OFFSET)
    else $error("accumulator write address wrong");
  a_add_zero_src: assert property (
    (state == CALC && op == float_add_op && float_source.exp == 8'h00)
    |=> float_temp_result == $past(float_accumulator))
    else $error("adding zero changed the accumulator");
  a_sub_equal_zero: assert property (
    (state == CALC && op == float_subtract_op && float_accumulator == float_source)
    |=> float_temp_result == 32'h0000_0000)
    else $error("subtracting equal operands not zero");
  a_mul_sign: assert property (
    (state == CALC && op == float_multiply_op && next_result != 32'h0000_0000)
    |=> float_temp_result.sign == $past(float_accumulator.sign ^ float_source.sign))
    else $error("product sign wrong");
  a_div_zero_carry: assert property (
    (state == CALC && op == float_divide_op && float_source.exp == 8'h00)
    |=> DONE_OUT && FLAGS_OUT.c && !MEM_WE_OUT)
    else $error("divide by zero not flagged or wrote");
  a_range_no_write: assert property (
    (state == CALC && (ovf || unf)) |=> !MEM_REQ_OUT ##1 state == IDLE)
    else $error("out of range result written");
  a_write_data: assert property (
    (MEM_WE_OUT && word_idx == 2'h1) |-> MEM_WDATA_OUT == float_temp_result[15:0])
    else $error("low write word not the temp result");
  // no-store cases keep the fetched accumulator, stored cases show the temp result
  a_neg_flag: assert property (
    DONE_OUT |-> FLAGS_OUT.n == ((FLAGS_OUT.v || FLAGS_OUT.c)
                                 ? (float_accumulator.sign | unf_q)
                                 : float_temp_result.sign))
    else $error("negative flag wrong");
  // overflow is tied to the skipped write, independent of the limit compare
  a_ovf_flag: assert property (
    DONE_OUT |-> FLAGS_OUT.v == (!$past(MEM_WE_OUT) && !FLAGS_OUT.c))
    else $error("overflow flag wrong");
  a_zero_carry: assert property (
    DONE_OUT |-> (FLAGS_OUT.z == ((FLAGS_OUT.v || FLAGS_OUT.c)
                                  ? (float_accumulator == 32'h0000_0000)
                                  : (float_temp_result == 32'h0000_0000)))
                 && (FLAGS_OUT.c == (op == float_divide_op && float_source.exp == 8'h00)))
    else $error("zero or carry flag wrong");

  c_add_store: cover property (state == CALC && op == float_add_op && store ##1 MEM_WE_OUT);
  c_div_zero:  cover property (state == CALC && div_zero);
  c_overflow:  cover property (state == CALC && ovf);
  c_mul_done:  cover property (DONE_OUT && op == float_multiply_op);

endmodule

// ### test/float_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// host memory holding the operand stack
// ****************************************
module float_mem_model (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic [3:0]  delay_in,
  output logic             ack_out,
  output logic [15:0]      rdata_out
);
  logic [15:0] words [0:127];
  logic [3:0]  wait_cnt    = 4'h0;
  logic [15:0] last_word   = 16'h0000;
  int          write_total = 0;

  // ack after the chosen number of wait cycles, zero means same cycle
  assign ack_out = req_in && (wait_cnt == delay_in);

  // data only valid with ack; otherwise the inverse, so early sampling shows
  assign rdata_out = ack_out ? words[addr_in[7:1]] : ~last_word;

  // wait counter restarts after each completed word
  always @(posedge clk_in)
  begin
    if (req_in && !ack_out)
      wait_cnt <= wait_cnt + 4'h1;
    else
      wait_cnt <= 4'h0;
    if (ack_out && we_in)
    begin
      words[addr_in[7:1]] <= wdata_in;
      write_total <= write_total + 1;
    end
    if (ack_out)
      last_word <= we_in ? wdata_in : words[addr_in[7:1]];
  end
endmodule

// ### test/float_arith_unit_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module float_arith_unit_bench
  import float_arith_pkg::*;
;
  localparam logic [22:0] FQ = 23'h20_0000;
  localparam logic [22:0] FZ = 23'h00_0000;
  logic [15:0] ptr       = 16'h0010;
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [15:0] opcode    = 16'h0000;
  logic [3:0]  dly       = 4'h0;
  logic        ready;
  logic        req;
  logic        we;
  logic        ack;
  logic        done;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  cond_codes_t flags;
  cond_codes_t got_flags;
  logic [31:0] got_acc;
  logic        done_seen;
  int          wrote;
  int          fail_count  = 0;
  int          checks_done = 0;

  float_arith_unit DUT (.SYS_CLK_IN(clk), .RST_IN(rst), .CMD_VALID_IN(cmd_valid),
    .CMD_OPCODE_IN(opcode), .OPERAND_POINTER_IN(ptr), .CMD_READY_OUT(ready),
    .MEM_REQ_OUT(req), .MEM_WE_OUT(we), .MEM_ADDR_OUT(addr), .MEM_WDATA_OUT(wdata),
    .MEM_ACK_IN(ack), .MEM_RDATA_IN(rdata), .DONE_OUT(done), .FLAGS_OUT(flags));

  float_mem_model mem (.clk_in(clk), .req_in(req), .we_in(we), .addr_in(addr),
    .wdata_in(wdata), .delay_in(dly), .ack_out(ack), .rdata_out(rdata));

  // 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // shared drivers and judges
  // ****************************************
  function automatic logic [31:0] fw(input logic s, input logic [7:0] e,
                                     input logic [22:0] f);
    return {s, e, f};
  endfunction

  // operands sit at the pointer; the wait is bounded since acks may stall
  task automatic issue(input logic [10:0] pre, input float_op_t op,
                       input logic [31:0] acc, input logic [31:0] src, input logic [3:0] d);
    int n;
    int w0;
    int b;
    @(posedge clk);
    #2;
    b = int'(ptr[7:1]);
    {mem.words[b], mem.words[b+1]} = src;
    {mem.words[b+2], mem.words[b+3]} = acc;
    dly = d;
    w0 = mem.write_total;
    cmd_valid = 1'b1;
    opcode = {pre, op, 3'b101};
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    done_seen = 1'b0;
    for (n = 0; n < 200 && !done_seen; n++)
    begin
      @(posedge clk);
      #2;
      done_seen = (done === 1'b1);
    end
    got_flags = flags;
    got_acc = {mem.words[b+2], mem.words[b+3]};
    wrote = mem.write_total - w0;
  endtask

  task automatic judge(input logic [31:0] a, input logic [3:0] f, input int w);
    `CHK(done_seen, 1'b1)
    `CHK(got_acc, a)
    `CHK(got_flags, cond_codes_t'(f))
    `CHK(wrote, w)
  endtask

  // power-of-two results: sign, exact exponent, empty fraction
  task automatic judge_near(input logic s, input logic [7:0] e0, input logic [3:0] f);
    `CHK(done_seen, 1'b1)
    `CHK(got_acc[31], s)
    `CHK(got_acc[22:0], 23'h00_0000)
    `CHK(got_acc[30:23], e0)
    `CHK(got_flags, cond_codes_t'(f))
    `CHK(wrote, 2)
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // equal sum, then a zero source that must hand the accumulator back
  task automatic t_add();
    issue(FLOAT_OPCODE_PREFIX, float_add_op, fw(1'b0, 8'h90, FQ), fw(1'b0, 8'h90, FQ), 4'h3);
    judge(fw(1'b0, 8'h91, FQ), 4'b0000, 2);
    issue(FLOAT_OPCODE_PREFIX, float_add_op, fw(1'b0, 8'h90, FQ), 32'h0000_0000, 4'h1);
    judge(fw(1'b0, 8'h90, FQ), 4'b0000, 2);
  endtask

  task automatic t_sub();
    issue(FLOAT_OPCODE_PREFIX, float_subtract_op, fw(1'b0, 8'h91, FQ), fw(1'b0, 8'h90, FQ), 4'h0);
    judge(fw(1'b0, 8'h90, FQ), 4'b0000, 2);
    issue(FLOAT_OPCODE_PREFIX, float_subtract_op, fw(1'b1, 8'h88, FQ), fw(1'b1, 8'h88, FQ), 4'h1);
    judge(32'h0000_0000, 4'b0100, 2);
  endtask

  // pointer moved: every fetch and write must follow it
  task automatic t_mul();
    ptr = 16'h0040;
    issue(FLOAT_OPCODE_PREFIX, float_multiply_op, fw(1'b1, 8'h85, FZ), fw(1'b0, 8'h83, FZ), 4'h0);
    judge_near(1'b1, 8'h88, 4'b1000);
  endtask

  task automatic t_div();
    issue(FLOAT_OPCODE_PREFIX, float_divide_op, fw(1'b0, 8'h90, FZ), fw(1'b1, 8'h8e, FZ), 4'h3);
    judge_near(1'b1, 8'h82, 4'b1000);
  endtask

  // zero divisor leaves the accumulator and raises carry, with negative set from the accumulator's sign
  task automatic t_div_zero();
    issue(FLOAT_OPCODE_PREFIX, float_divide_op, fw(1'b1, 8'h90, FQ), 32'h0000_0000, 4'h0);
    judge(fw(1'b1, 8'h90, FQ), 4'b1001, 0);
  endtask

  task automatic t_limits();
    issue(FLOAT_OPCODE_PREFIX, float_add_op, fw(1'b0, 8'hff, FQ), fw(1'b0, 8'hff, FQ), 4'h2);
    judge(fw(1'b0, 8'hff, FQ), 4'b0010, 0);
    issue(FLOAT_OPCODE_PREFIX, float_multiply_op, fw(1'b0, 8'h01, FZ), fw(1'b0, 8'h01, FZ), 4'h0);
    judge(fw(1'b0, 8'h01, FZ), 4'b1010, 0);
  endtask

  // a foreign opcode must draw no answer at all
  task automatic t_foreign();
    issue(11'h3d1, float_add_op, fw(1'b0, 8'h90, FQ), fw(1'b0, 8'h90, FQ), 4'h0);
    `CHK(done_seen, 1'b0)
    `CHK(wrote, 0)
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic conclude();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #(25 * 5000);
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    `CHK(ready, 1'b1)
    `CHK(flags, cond_codes_t'(4'b0000))
    t_add();
    t_sub();
    t_mul();
    t_div();
    t_div_zero();
    t_limits();
    t_foreign();
    conclude();
  end
endmodule
